// File: verilog/usbep_engine.sv
// module: endpoint response engine of the usb protocol engine with APB regs
//
// Contract
// RULE1: mode 0000 gives no response at all to SETUP, IN or OUT.
// RULE2: control endpoint goes to 0001 after ACKing a SETUP.
// RULE3: 0001 accepts SETUP, NAKs IN/OUT; 1011 NAKs IN, ACKs OUT, then 0001.
// RULE4: 1001 ignores SETUP/IN; OUT gets ACK or STALL; ACK moves to 1000.
// RULE5: 1000 ignores SETUP and IN, NAKs every OUT.
// RULE6: 1101 sends count on IN or STALL; host ACK moves to 1100.
// RULE7: 1100 ignores SETUP and OUT, NAKs every IN.
// RULE8: 1111 accepts SETUP, sends count, checks OUT; IN ACK moves to 1110.
// RULE9: 1110 accepts SETUP, NAKs IN, checks status OUT.
// RULE10: control-only modes 0010, 0011, 0100, 0110, 1010 answer per table.
// RULE11: interrupt enable holds data endpoints in bits 2:1, control in bit 0.
// RULE12: an endpoint interrupt fires only while its enable bit is one.
// RULE13: data endpoints interrupt on received data; ACK-OUT modes on any data.
// RULE14: firmware checks data validity after an ACK-OUT interrupt.
// RULE15: NAK or STALL sent to IN or OUT raises the endpoint interrupt.
// RULE16: data endpoint interrupts when host ACKs its IN data.
// RULE17: control interrupts on SETUP, after status zero-length, and on data.
// RULE18: all mode fields reset to 0000 and stay until firmware writes.
// RULE19: status check ACKs only zero-byte OUT with toggle one.
// RULE20: after an ACK on control, mode and count lock until a CPU read.
// RULE21: data valid only if length fits size plus two CRC and checks pass.
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/1ps

module usbep_engine
  import usbep_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // apb slave
  input usbep_apb_req_t apbReq,
  output usbep_apb_rsp_t apbRsp,
  // token side from the packet layer
  input usbep_tok_t tok,
  input wire logic hostAck,
  // handshake and data answer
  output usbep_rsp_t rsp,
  // endpoint interrupts, one-cycle pulses
  output logic [2:0] epIrq
);

  // ==========================================================
  // state
  usbep_state_t s;
  usbep_state_t n;
  usbep_act_t setupAct [3];
  usbep_act_t inAct [3];
  usbep_act_t outAct [3];
  logic [2:0] ev;
  logic [1:0] e;
  logic dataOk;
  logic [5:0] idx;
  logic hit;
  logic [31:0] rd;
  logic apbSetup;
  logic apbAccess;

  // ==========================================================
  // mode decoders, one per endpoint
  // the control endpoint has no stall bit in its mode register
  for (genvar i = 0; i < 3; i++)
  begin : g_dec
    usbep_mode_decode u_dec (
      .mode(s.mode[i][3:0]),
      .stall(i == 0 ? 1'b0 : s.mode[i][USBEP_STALL_BIT]),
      .setupAct(setupAct[i]),
      .inAct(inAct[i]),
      .outAct(outAct[i])
    );
  end

  // ==========================================================
  // apb decode
  assign apbSetup = apbReq.psel & ~apbReq.penable;
  assign apbAccess = apbReq.psel & apbReq.penable;
  assign idx = apbReq.paddr[7:2];

  // read mux, captured at the setup cycle so prdata is a flop
  always_comb
  begin
    hit = (apbReq.paddr[1:0] == 2'h0);
    rd = 32'h0000_0000;
    unique case (idx)
      USBEP_IDX_MODE0: rd[7:0] = s.mode[0];
      USBEP_IDX_MODE1: rd[7:0] = s.mode[1];
      USBEP_IDX_MODE2: rd[7:0] = s.mode[2];
      USBEP_IDX_CNT0: rd[3:0] = s.count[0];
      USBEP_IDX_CNT1: rd[3:0] = s.count[1];
      USBEP_IDX_CNT2: rd[3:0] = s.count[2];
      USBEP_IDX_STAT:
      begin
        rd[USBEP_STAT_LOCK] = s.lock;
        rd[USBEP_STAT_WAIT] = (s.state == USBEP_ST_WAIT_ACK);
      end
      USBEP_IDX_IRQEN: rd[2:0] = s.irqEn; // see RULE11
      default: hit = 1'b0;
    endcase
  end

  // ==========================================================
  // next state: bus first, then the engine, so hardware sets win
  always_comb
  begin
    n = s;
    ev = 3'h0;
    e = tok.ep;
    dataOk = 1'b0;
    n.rsp.valid = 1'b0;

    // apb setup: capture read data and error
    if (apbSetup)
    begin
      n.rdata = rd;
      n.err = ~hit;
    end

    // apb access: writes and unlocking reads
    if (apbAccess && !s.err)
    begin
      if (apbReq.pwrite)
      begin
        unique case (idx)
          USBEP_IDX_MODE0:
          begin
            // flags clear on write; locked writes are dropped
            if (!s.lock)
            begin
              n.mode[0] = {4'h0, apbReq.pwdata[3:0]}; // see RULE20
            end
          end
          USBEP_IDX_MODE1:
          begin
            n.mode[1] = {apbReq.pwdata[7], 3'h0, apbReq.pwdata[3:0]};
          end
          USBEP_IDX_MODE2:
          begin
            n.mode[2] = {apbReq.pwdata[7], 3'h0, apbReq.pwdata[3:0]};
          end
          USBEP_IDX_CNT0:
          begin
            if (!s.lock)
            begin
              n.count[0] = apbReq.pwdata[3:0]; // see RULE20
            end
          end
          USBEP_IDX_CNT1: n.count[1] = apbReq.pwdata[3:0];
          USBEP_IDX_CNT2: n.count[2] = apbReq.pwdata[3:0];
          USBEP_IDX_IRQEN: n.irqEn = apbReq.pwdata[2:0]; // see RULE11
          default: n.err = s.err;
        endcase
      end
      else if (idx == USBEP_IDX_MODE0 || idx == USBEP_IDX_CNT0)
      begin
        // reading either control register releases the interlock
        n.lock = 1'b0; // see RULE20
      end
    end

    // token handling; endpoint index 3 does not exist and is ignored
    if (tok.valid && tok.ep != 2'h3)
    begin
      // a new token abandons any IN that the host never ACKed
      n.state = USBEP_ST_IDLE;
      n.rsp.ep = e;
      n.rsp.count = 4'h0;
      dataOk = tok.checksOk &&
        (tok.rxLen <= USBEP_EP_SIZE + USBEP_CRC_BYTES); // see RULE21
      unique case (tok.pid)
        USBEP_PID_SETUP:
        begin
          if (setupAct[e] == USBEP_ACT_ACCEPT)
          begin
            // setup traffic interrupts even when the data was bad
            ev[e] = 1'b1; // see RULE17
            if (e == 2'h0)
            begin
              n.mode[0][USBEP_FLAG_SETUP] = 1'b1;
            end
            if (dataOk)
            begin
              n.rsp.valid = 1'b1;
              n.rsp.kind = USBEP_RSP_ACK;
              n.mode[e][3:0] = USBEP_M_NAK_INOUT; // see RULE2
              if (e == 2'h0)
              begin
                n.lock = 1'b1; // see RULE20
              end
            end
          end
        end
        USBEP_PID_OUT:
        begin
          unique case (outAct[e])
            USBEP_ACT_NAK, USBEP_ACT_STALL:
            begin
              ev[e] = 1'b1; // see RULE15
              n.rsp.valid = 1'b1;
              n.rsp.kind = (outAct[e] == USBEP_ACT_NAK) ?
                USBEP_RSP_NAK : USBEP_RSP_STALL; // see RULE5
            end
            USBEP_ACT_ACK:
            begin
              // ACK-OUT modes interrupt on any packet, bad CRC too
              ev[e] = 1'b1; // see RULE13
              if (dataOk)
              begin
                n.rsp.valid = 1'b1;
                n.rsp.kind = USBEP_RSP_ACK;
                if (s.mode[e][3:0] == USBEP_M_ACKOUT_NAKIN)
                begin
                  n.mode[e][3:0] = USBEP_M_NAK_INOUT; // see RULE3
                end
                else
                begin
                  n.mode[e][3:0] = USBEP_M_NAK_OUT; // see RULE4
                end
                if (e == 2'h0)
                begin
                  n.lock = 1'b1; // see RULE20
                end
              end
            end
            USBEP_ACT_CHECK:
            begin
              // corrupt packets get no handshake at all
              if (dataOk)
              begin
                ev[e] = 1'b1; // see RULE17
                n.rsp.valid = 1'b1;
                if (tok.rxLen == USBEP_CRC_BYTES && tok.toggle)
                begin
                  n.rsp.kind = USBEP_RSP_ACK; // see RULE19
                  if (e == 2'h0)
                  begin
                    n.lock = 1'b1; // see RULE20
                  end
                end
                else
                begin
                  n.rsp.kind = USBEP_RSP_STALL; // see RULE19
                end
              end
            end
            default: n.rsp.valid = 1'b0; // see RULE1
          endcase
          if (e == 2'h0 && outAct[0] != USBEP_ACT_IGNORE)
          begin
            n.mode[0][USBEP_FLAG_OUT] = 1'b1;
          end
        end
        USBEP_PID_IN:
        begin
          unique case (inAct[e])
            USBEP_ACT_NAK, USBEP_ACT_STALL:
            begin
              ev[e] = 1'b1; // see RULE15
              n.rsp.valid = 1'b1;
              n.rsp.kind = (inAct[e] == USBEP_ACT_NAK) ?
                USBEP_RSP_NAK : USBEP_RSP_STALL; // see RULE7
            end
            USBEP_ACT_TXCNT, USBEP_ACT_TX0:
            begin
              // wait for the host ACK before counting it done
              n.rsp.valid = 1'b1;
              n.rsp.kind = (inAct[e] == USBEP_ACT_TXCNT) ?
                USBEP_RSP_DATA : USBEP_RSP_ZLP;
              n.rsp.count = (inAct[e] == USBEP_ACT_TXCNT) ?
                s.count[e] : 4'h0; // see RULE6
              n.state = USBEP_ST_WAIT_ACK;
              n.ackEp = e;
            end
            default: n.rsp.valid = 1'b0; // see RULE1
          endcase
          if (e == 2'h0 && inAct[0] != USBEP_ACT_IGNORE)
          begin
            n.mode[0][USBEP_FLAG_IN] = 1'b1;
          end
        end
        default: n.rsp.valid = 1'b0;
      endcase
    end
    else
    begin
      unique case (s.state)
        USBEP_ST_IDLE: n.state = USBEP_ST_IDLE;
        USBEP_ST_WAIT_ACK:
        begin
          if (hostAck)
          begin
            // host took the IN data or the status zero-length packet
            n.state = USBEP_ST_IDLE;
            ev[s.ackEp] = 1'b1; // see RULE16
            if (s.mode[s.ackEp][3:0] == USBEP_M_ACK_IN)
            begin
              n.mode[s.ackEp][3:0] = USBEP_M_NAK_IN; // see RULE6
            end
            if (s.mode[s.ackEp][3:0] == USBEP_M_ACKIN_STOUT)
            begin
              n.mode[s.ackEp][3:0] = USBEP_M_NAKIN_STOUT; // see RULE8
            end
            if (s.ackEp == 2'h0)
            begin
              n.lock = 1'b1; // see RULE20
            end
          end
        end
        default: n.state = USBEP_ST_IDLE;
      endcase
    end

    // interrupts are gated by their enables
    n.irq = ev & s.irqEn; // see RULE12
  end

  // ==========================================================
  // state register
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      s <= '0;
      s.mode <= {3{USBEP_MODE_RST}}; // see RULE18
      s.count <= {3{USBEP_CNT_RST}};
      s.irqEn <= USBEP_IRQEN_RST;
      s.state <= USBEP_ST_IDLE;
    end
    else
    begin
      s <= n;
    end
  end

  // ==========================================================
  // outputs; the slave answers in the first access cycle
  assign apbRsp.pready = apbAccess;
  assign apbRsp.prdata = s.rdata;
  assign apbRsp.pslverr = apbAccess & s.err;
  assign rsp = s.rsp;
  assign epIrq = s.irq;

endmodule

// File: inc/usbep_pkg.sv
// package: register map, mode codes and carriers of the usb endpoint engine
package usbep_pkg;

  // ==========================================================
  // register indices (byte address = index * 4)
  localparam logic [5:0] USBEP_IDX_MODE0 = 6'h10;
  localparam logic [5:0] USBEP_IDX_MODE1 = 6'h11;
  localparam logic [5:0] USBEP_IDX_MODE2 = 6'h12;
  localparam logic [5:0] USBEP_IDX_CNT0 = 6'h13;
  localparam logic [5:0] USBEP_IDX_CNT1 = 6'h14;
  localparam logic [5:0] USBEP_IDX_CNT2 = 6'h15;
  localparam logic [5:0] USBEP_IDX_STAT = 6'h16;
  localparam logic [5:0] USBEP_IDX_IRQEN = 6'h21;

  // ==========================================================
  // field positions
  localparam int USBEP_STALL_BIT = 7;
  localparam int USBEP_FLAG_SETUP = 6;
  localparam int USBEP_FLAG_IN = 5;
  localparam int USBEP_FLAG_OUT = 4;
  localparam int USBEP_STAT_LOCK = 0;
  localparam int USBEP_STAT_WAIT = 1;

  // ==========================================================
  // reset values
  localparam logic [7:0] USBEP_MODE_RST = 8'h00;
  localparam logic [3:0] USBEP_CNT_RST = 4'h0;
  localparam logic [2:0] USBEP_IRQEN_RST = 3'h0;

  // ==========================================================
  // endpoint sizes
  localparam logic [4:0] USBEP_EP_SIZE = 5'h08;
  localparam logic [4:0] USBEP_CRC_BYTES = 5'h02;

  // ==========================================================
  // endpoint mode codes
  localparam logic [3:0] USBEP_M_DISABLE = 4'h0;
  localparam logic [3:0] USBEP_M_NAK_INOUT = 4'h1;
  localparam logic [3:0] USBEP_M_STATUS_OUT = 4'h2;
  localparam logic [3:0] USBEP_M_STALL_INOUT = 4'h3;
  localparam logic [3:0] USBEP_M_IGN_INOUT = 4'h4;
  localparam logic [3:0] USBEP_M_RSV5 = 4'h5;
  localparam logic [3:0] USBEP_M_STATUS_IN = 4'h6;
  localparam logic [3:0] USBEP_M_RSV7 = 4'h7;
  localparam logic [3:0] USBEP_M_NAK_OUT = 4'h8;
  localparam logic [3:0] USBEP_M_ACK_OUT = 4'h9;
  localparam logic [3:0] USBEP_M_NAKOUT_STIN = 4'hA;
  localparam logic [3:0] USBEP_M_ACKOUT_NAKIN = 4'hB;
  localparam logic [3:0] USBEP_M_NAK_IN = 4'hC;
  localparam logic [3:0] USBEP_M_ACK_IN = 4'hD;
  localparam logic [3:0] USBEP_M_NAKIN_STOUT = 4'hE;
  localparam logic [3:0] USBEP_M_ACKIN_STOUT = 4'hF;

  // ==========================================================
  // enumerations
  typedef enum logic [1:0] {
    USBEP_PID_SETUP = 2'h0,
    USBEP_PID_IN = 2'h1,
    USBEP_PID_OUT = 2'h2
  } usbep_pid_t;

  typedef enum logic [2:0] {
    USBEP_ACT_IGNORE = 3'h0,
    USBEP_ACT_ACCEPT = 3'h1,
    USBEP_ACT_NAK = 3'h2,
    USBEP_ACT_STALL = 3'h3,
    USBEP_ACT_ACK = 3'h4,
    USBEP_ACT_TXCNT = 3'h5,
    USBEP_ACT_TX0 = 3'h6,
    USBEP_ACT_CHECK = 3'h7
  } usbep_act_t;

  typedef enum logic [2:0] {
    USBEP_RSP_ACK = 3'h0,
    USBEP_RSP_NAK = 3'h1,
    USBEP_RSP_STALL = 3'h2,
    USBEP_RSP_DATA = 3'h3,
    USBEP_RSP_ZLP = 3'h4
  } usbep_rsp_kind_t;

  typedef enum logic [1:0] {
    USBEP_ST_IDLE = 2'b01,
    USBEP_ST_WAIT_ACK = 2'b10
  } usbep_fsm_t;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } usbep_apb_req_t;

  typedef struct packed {
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
  } usbep_apb_rsp_t;

  typedef struct packed {
    logic valid;
    usbep_pid_t pid;
    logic [1:0] ep;
    logic [4:0] rxLen;
    logic checksOk;
    logic toggle;
  } usbep_tok_t;

  typedef struct packed {
    logic valid;
    usbep_rsp_kind_t kind;
    logic [1:0] ep;
    logic [3:0] count;
  } usbep_rsp_t;

  typedef struct packed {
    logic [2:0][7:0] mode;
    logic [2:0][3:0] count;
    logic [2:0] irqEn;
    logic [2:0] irq;
    logic lock;
    usbep_fsm_t state;
    logic [1:0] ackEp;
    usbep_rsp_t rsp;
    logic [31:0] rdata;
    logic err;
  } usbep_state_t;

endpackage

// File: verilog/usbep_mode_decode.sv
// module: decodes an endpoint mode into its SETUP, IN and OUT actions
`timescale 1ns/1ps

module usbep_mode_decode
  import usbep_pkg::*;
(
  // mode of one endpoint
  input wire logic [3:0] mode,
  input wire logic stall,
  // actions per token
  output usbep_act_t setupAct,
  output usbep_act_t inAct,
  output usbep_act_t outAct
);

  // ==========================================================
  // mode table
  // every one of the 16 codes has a case item, so no default is needed
  always_comb
  begin
    setupAct = USBEP_ACT_IGNORE;
    inAct = USBEP_ACT_IGNORE;
    outAct = USBEP_ACT_IGNORE;
    unique case (mode)
      USBEP_M_DISABLE:
      begin
        setupAct = USBEP_ACT_IGNORE; // see RULE1
      end
      USBEP_M_NAK_INOUT:
      begin
        setupAct = USBEP_ACT_ACCEPT; // see RULE3
        inAct = USBEP_ACT_NAK;
        outAct = USBEP_ACT_NAK;
      end
      USBEP_M_STATUS_OUT:
      begin
        setupAct = USBEP_ACT_ACCEPT; // see RULE10
        inAct = USBEP_ACT_STALL;
        outAct = USBEP_ACT_CHECK;
      end
      USBEP_M_STALL_INOUT:
      begin
        setupAct = USBEP_ACT_ACCEPT; // see RULE10
        inAct = USBEP_ACT_STALL;
        outAct = USBEP_ACT_STALL;
      end
      USBEP_M_IGN_INOUT:
      begin
        setupAct = USBEP_ACT_ACCEPT; // see RULE10
      end
      USBEP_M_RSV5:
      begin
        // reserved: treated as fully ignoring
        setupAct = USBEP_ACT_IGNORE;
      end
      USBEP_M_STATUS_IN:
      begin
        setupAct = USBEP_ACT_ACCEPT; // see RULE10
        inAct = USBEP_ACT_TX0;
        outAct = USBEP_ACT_STALL;
      end
      USBEP_M_RSV7:
      begin
        inAct = USBEP_ACT_TXCNT;
      end
      USBEP_M_NAK_OUT:
      begin
        outAct = USBEP_ACT_NAK; // see RULE5
      end
      USBEP_M_ACK_OUT:
      begin
        // see RULE4
        outAct = stall ? USBEP_ACT_STALL : USBEP_ACT_ACK;
      end
      USBEP_M_NAKOUT_STIN:
      begin
        setupAct = USBEP_ACT_ACCEPT; // see RULE10
        inAct = USBEP_ACT_TX0;
        outAct = USBEP_ACT_NAK;
      end
      USBEP_M_ACKOUT_NAKIN:
      begin
        setupAct = USBEP_ACT_ACCEPT; // see RULE3
        inAct = USBEP_ACT_NAK;
        outAct = USBEP_ACT_ACK;
      end
      USBEP_M_NAK_IN:
      begin
        inAct = USBEP_ACT_NAK; // see RULE7
      end
      USBEP_M_ACK_IN:
      begin
        // see RULE6
        inAct = stall ? USBEP_ACT_STALL : USBEP_ACT_TXCNT;
      end
      USBEP_M_NAKIN_STOUT:
      begin
        setupAct = USBEP_ACT_ACCEPT; // see RULE9
        inAct = USBEP_ACT_NAK;
        outAct = USBEP_ACT_CHECK;
      end
      USBEP_M_ACKIN_STOUT:
      begin
        setupAct = USBEP_ACT_ACCEPT; // see RULE8
        inAct = USBEP_ACT_TXCNT;
        outAct = USBEP_ACT_CHECK;
      end
    endcase
  end

endmodule

// File: testbench/usbep_engine_checker.sv
// checker: concurrent assertions on the ports of the endpoint engine
`timescale 1ns/1ps

module usbep_engine_checker
  import usbep_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // register bus
  input usbep_apb_req_t apbReq,
  input usbep_apb_rsp_t apbRsp,
  // token side and answers
  input usbep_tok_t tok,
  input wire logic hostAck,
  input usbep_rsp_t rsp,
  input wire logic [2:0] epIrq
);
  logic [2:0] enShadow;
  logic [2:0] enPrev;
  logic enWrite;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  // ==========================================================
  // enable shadow; enPrev is the value the engine used last edge
  assign enWrite = apbReq.psel && apbReq.penable && apbReq.pwrite;
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      enShadow <= 3'h0;
      enPrev <= 3'h0;
    end
    else
    begin
      enPrev <= enShadow;
      if (enWrite && apbReq.paddr == 8'h84)
        enShadow <= apbReq.pwdata[2:0];
    end
  end

  // ==========================================================
  // assertions
  AST_RSP_CAUSE: assert property (rsp.valid |->
    $past(tok.valid) && $past(tok.ep) != 2'h3)
    else $error("answer without a token");
  AST_RSP_EP: assert property (rsp.valid |->
    rsp.ep == $past(tok.ep))
    else $error("answer on wrong endpoint");
  AST_IN_KIND: assert property (rsp.valid &&
    $past(tok.pid) == USBEP_PID_IN |-> rsp.kind inside {USBEP_RSP_NAK,
    USBEP_RSP_STALL, USBEP_RSP_DATA, USBEP_RSP_ZLP})
    else $error("bad answer kind to IN");
  AST_OUT_KIND: assert property (rsp.valid &&
    $past(tok.pid) == USBEP_PID_OUT |-> rsp.kind inside {USBEP_RSP_ACK,
    USBEP_RSP_NAK, USBEP_RSP_STALL})
    else $error("bad answer kind to OUT");
  AST_SETUP_ACK: assert property (rsp.valid &&
    $past(tok.pid) == USBEP_PID_SETUP |-> rsp.kind == USBEP_RSP_ACK)
    else $error("SETUP answered other than ACK");
  AST_ACK_VALID: assert property (rsp.valid &&
    rsp.kind == USBEP_RSP_ACK |-> $past(tok.checksOk) &&
    $past(tok.rxLen) <= 5'h0A)
    else $error("ACK to a bad data packet");
  AST_IRQ_MASK: assert property ((epIrq & ~enPrev) == 3'h0)
    else $error("interrupt on a disabled endpoint");
  AST_NAK_IRQ: assert property (rsp.valid &&
    rsp.kind inside {USBEP_RSP_NAK, USBEP_RSP_STALL} |->
    epIrq[rsp.ep] == enPrev[rsp.ep])
    else $error("NAK or STALL without interrupt");
  AST_TX_NO_IRQ: assert property (rsp.valid &&
    rsp.kind inside {USBEP_RSP_DATA, USBEP_RSP_ZLP} |-> !epIrq[rsp.ep])
    else $error("interrupt before host ACK of IN data");
  AST_IRQ_CAUSE: assert property (epIrq != 3'h0 |->
    $past(tok.valid) || $past(hostAck))
    else $error("interrupt without a cause");
  AST_EN_READ: assert property (apbReq.psel && apbReq.penable &&
    !apbReq.pwrite && apbReq.paddr == 8'h84 |->
    apbRsp.prdata == {29'h0, enShadow})
    else $error("enable register reads wrong");

  // covers of the main scenarios
  C_DATA: cover property (rsp.valid && rsp.kind == USBEP_RSP_DATA);
  C_ACK: cover property (rsp.valid && rsp.kind == USBEP_RSP_ACK);
  C_IRQ0: cover property (epIrq[0]);
  C_HOSTACK: cover property (hostAck ##1 epIrq != 3'h0);
endmodule

// File: testbench/usbep_host_model.sv
// partner: host side model issuing tokens and IN acks to the engine
`timescale 1ns/1ps

module usbep_host_model
  import usbep_pkg::*;
(
  // clock
  input wire logic ref_clk,
  // token and ack drive
  output usbep_tok_t tok,
  output logic hostAck
);
  initial
  begin
    tok = '0;
    hostAck = 1'b0;
  end

  // one-edge token; idle fields inverted to expose late sampling
  task automatic send(input usbep_pid_t pid, input logic [1:0] ep,
    input logic [4:0] len, input logic ok, input logic tog);
    @(posedge ref_clk);
    tok <= '{valid: 1'b1, pid: pid, ep: ep, rxLen: len, checksOk: ok,
      toggle: tog};
    @(posedge ref_clk);
    tok <= {1'b0, ~tok[$bits(usbep_tok_t)-2:0]};
  endtask

  // host handshake after our IN data or zero-length packet
  task automatic ack_in();
    @(posedge ref_clk);
    hostAck <= 1'b1;
    @(posedge ref_clk);
    hostAck <= 1'b0;
  endtask
endmodule

// File: testbench/usb_endpoint_mode_and_irq_test.sv
// testbench: register and token sequences for the endpoint engine
`timescale 1ns/1ps

module usb_endpoint_mode_and_irq_test
  import usbep_pkg::*;
;
  localparam usbep_pid_t PS = USBEP_PID_SETUP;
  localparam usbep_pid_t PI = USBEP_PID_IN;
  localparam usbep_pid_t PO = USBEP_PID_OUT;
  // answer kinds; KX means none
  localparam logic [2:0] KA = 3'h0, KN = 3'h1, KS = 3'h2, KD = 3'h3;
  localparam logic [2:0] KZ = 3'h4, KX = 3'h7;

  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  usbep_apb_req_t apbReq = '0;
  usbep_apb_rsp_t apbRsp;
  usbep_tok_t tok;
  logic hostAck;
  usbep_rsp_t rsp;
  logic [2:0] epIrq;
  logic [31:0] rd;
  logic err;
  logic [1:0] tcEp = 2'h1;
  int failures = 0;
  int testsRun = 0;
  int cycles = 0;

  always #12.5 ref_clk = ~ref_clk;
  usbep_engine usbep_engine_inst (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .apbReq(apbReq), .apbRsp(apbRsp), .tok(tok), .hostAck(hostAck),
    .rsp(rsp), .epIrq(epIrq));
  usbep_host_model usbep_host_model_inst (.ref_clk(ref_clk), .tok(tok),
    .hostAck(hostAck));

  // ==========================================================
  // hang guard, far above the run's length
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      failures++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", testsRun, failures);
    if (failures == 0 && testsRun > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // ==========================================================
  // compare tasks
  task automatic cmp_word(input string name, input logic [31:0] exp,
    input logic [31:0] got);
    testsRun++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask
  // kind and count only matter while valid is up
  task automatic cmp_rsp(input logic [7:0] exp);
    logic [7:0] got;
    got = (rsp.valid === 1'b1) ? {1'b1, rsp.kind, rsp.count}
      : {rsp.valid, 7'h0};
    cmp_word("answer", {24'h0, exp}, {24'h0, got});
  endtask
  task automatic cmp_irq(input logic exp, input logic got);
    cmp_word("interrupt", {31'h0, exp}, {31'h0, got});
  endtask

  // ==========================================================
  // apb master: request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    @(posedge ref_clk);
    apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge ref_clk);
    apbReq.penable <= 1'b1;
    do
      @(posedge ref_clk);
    while (apbRsp.pready !== 1'b1);
    rd = apbRsp.prdata;
    err = apbRsp.pslverr;
    apbReq.psel <= 1'b0;
    apbReq.penable <= 1'b0;
  endtask

  // one mode case: set mode, send token, check answer, irq, new mode
  task automatic tc(input logic [7:0] mode, input usbep_pid_t pid,
    input logic [2:0] pkt, input logic [2:0] kind, input logic irq,
    input logic ack, input logic [3:0] endMode);
    logic [4:0] len;
    logic [7:0] a;
    // pkt 0 status ok, 1 four bytes, 2 bad crc, 3 too long, 4 toggle 0
    len = (pkt == 3'h3) ? 5'h0B : (pkt == 3'h0 || pkt == 3'h4) ? 5'h02
      : 5'h06;
    a = 8'h40 + {4'h0, tcEp, 2'h0};
    apb(1'b1, a, {24'h0, mode});
    usbep_host_model_inst.send(pid, tcEp, len, pkt != 3'h2, pkt == 3'h0);
    #1;
    cmp_rsp((kind == KX) ? 8'h00 : {1'b1, kind, (kind == KD) ? 4'h5 : 4'h0});
    cmp_irq(irq, epIrq[tcEp]);
    if (ack)
    begin
      usbep_host_model_inst.ack_in();
      #1;
      cmp_irq(1'b1, epIrq[tcEp]);
    end
    apb(1'b0, a, 32'h0);
    cmp_word("mode", {24'h0, mode[7], 3'h0, endMode}, rd);
  endtask

  // ==========================================================
  // main sequence
  initial
  begin
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 7; i++)
    begin
      apb(1'b0, 8'h40 + 8'(i * 4), 32'h0);
      cmp_word("reset value", 32'h0, rd);
    end
    apb(1'b0, 8'h84, 32'h0);
    cmp_word("enable reset", 32'h0, rd);
    apb(1'b0, 8'h3C, 32'h0);
    cmp_word("unmapped err", 32'h1, {31'h0, err});
    apb(1'b1, 8'h84, 32'hFFFFFFFF);
    apb(1'b0, 8'h84, 32'h0);
    cmp_word("enable bits", 32'h7, rd);
    $display("test registers done");
    apb(1'b1, 8'h50, 32'h5);
    apb(1'b1, 8'h54, 32'h5);
    tc(8'h00, PO, 3'h1, KX, 0, 0, 4'h0);
    tc(8'h00, PS, 3'h1, KX, 0, 0, 4'h0);
    tc(8'h01, PS, 3'h1, KA, 1, 0, 4'h1);
    tc(8'h01, PS, 3'h3, KX, 1, 0, 4'h1);
    tc(8'h01, PI, 3'h1, KN, 1, 0, 4'h1);
    tc(8'h01, PO, 3'h1, KN, 1, 0, 4'h1);
    tc(8'h0B, PI, 3'h1, KN, 1, 0, 4'hB);
    tc(8'h0B, PO, 3'h1, KA, 1, 0, 4'h1);
    tc(8'h0B, PO, 3'h2, KX, 1, 0, 4'hB);
    tc(8'h0B, PO, 3'h3, KX, 1, 0, 4'hB);
    tc(8'h09, PO, 3'h1, KA, 1, 0, 4'h8);
    tc(8'h89, PO, 3'h1, KS, 1, 0, 4'h9);
    tc(8'h09, PI, 3'h1, KX, 0, 0, 4'h9);
    tc(8'h09, PS, 3'h1, KX, 0, 0, 4'h9);
    tc(8'h08, PO, 3'h1, KN, 1, 0, 4'h8);
    tc(8'h08, PI, 3'h1, KX, 0, 0, 4'h8);
    tc(8'h0D, PI, 3'h1, KD, 0, 1, 4'hC);
    tc(8'h8D, PI, 3'h1, KS, 1, 0, 4'hD);
    tc(8'h0D, PO, 3'h1, KX, 0, 0, 4'hD);
    tc(8'h0C, PI, 3'h1, KN, 1, 0, 4'hC);
    tc(8'h0C, PS, 3'h1, KX, 0, 0, 4'hC);
    tc(8'h0F, PI, 3'h1, KD, 0, 1, 4'hE);
    tc(8'h0F, PS, 3'h1, KA, 1, 0, 4'h1);
    tc(8'h0E, PI, 3'h1, KN, 1, 0, 4'hE);
    tc(8'h0E, PO, 3'h0, KA, 1, 0, 4'hE);
    tc(8'h0E, PO, 3'h4, KS, 1, 0, 4'hE);
    tc(8'h0E, PO, 3'h1, KS, 1, 0, 4'hE);
    tc(8'h0E, PO, 3'h2, KX, 0, 0, 4'hE);
    tc(8'h02, PI, 3'h1, KS, 1, 0, 4'h2);
    tc(8'h02, PO, 3'h0, KA, 1, 0, 4'h2);
    tc(8'h03, PO, 3'h1, KS, 1, 0, 4'h3);
    tc(8'h04, PI, 3'h1, KX, 0, 0, 4'h4);
    tc(8'h06, PI, 3'h1, KZ, 0, 1, 4'h6);
    tc(8'h06, PO, 3'h1, KS, 1, 0, 4'h6);
    tc(8'h0A, PI, 3'h1, KZ, 0, 1, 4'hA);
    tc(8'h0A, PO, 3'h1, KN, 1, 0, 4'hA);
    tc(8'h07, PI, 3'h1, KD, 0, 1, 4'h7);
    tc(8'h05, PO, 3'h1, KX, 0, 0, 4'h5);
    tcEp = 2'h2;
    tc(8'h0D, PI, 3'h1, KD, 0, 1, 4'hC);
    tc(8'h08, PO, 3'h1, KN, 1, 0, 4'h8);
    $display("test modes done");
    apb(1'b1, 8'h84, 32'h5);
    tc(8'h08, PO, 3'h1, KN, 1, 0, 4'h8);
    tcEp = 2'h1;
    tc(8'h01, PI, 3'h1, KN, 0, 0, 4'h1);
    $display("test masking done");
    apb(1'b1, 8'h40, 32'h4);
    usbep_host_model_inst.send(PS, 2'h0, 5'h0A, 1'b1, 1'b0);
    #1;
    cmp_rsp({1'b1, KA, 4'h0});
    cmp_irq(1'b1, epIrq[0]);
    apb(1'b1, 8'h40, 32'h3);
    apb(1'b0, 8'h40, 32'h0);
    cmp_word("locked mode0", 32'h41, rd);
    apb(1'b1, 8'h40, 32'h3);
    apb(1'b0, 8'h40, 32'h0);
    cmp_word("unlocked mode0", 32'h3, rd);
    $display("test control done");
    give_verdict();
  end
endmodule

bind usbep_engine usbep_engine_checker usbep_engine_checker_inst (
  .ref_clk(ref_clk), .sys_rst(sys_rst), .apbReq(apbReq), .apbRsp(apbRsp),
  .tok(tok), .hostAck(hostAck), .rsp(rsp), .epIrq(epIrq));
